// >>> design/combined_touch_irq_pkg.sv
// constants for the touch converter interrupt and sequence timing block
package combined_touch_irq_pkg;
  localparam logic [7:0] OFS_GEN_CONFIG = 8'h00;
  localparam logic [7:0] OFS_GEN_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_MASKED_STATUS = 8'h14;
  localparam logic [7:0] OFS_SEQ_CONFIG = 8'h18;
  localparam logic [7:0] OFS_FIFO_DATA = 8'h1c;
  localparam logic [7:0] OFS_BIAS_CTRL = 8'h20;
  // irq bit positions
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_WATERMARK = 1;
  localparam int BIT_SEQ_DONE = 2;
  localparam int BIT_TOUCH = 3;
  localparam int BIT_SUPPLY = 4;
  // clear register bits
  localparam int BIT_CLR_SEQ_DONE = 0;
  localparam int BIT_CLR_TOUCH = 1;
  localparam int BIT_CLR_SUPPLY = 2;
  // general config fields
  localparam int BIT_CFG_CONTINUOUS = 0;
  localparam int BIT_CFG_TOUCH_TRIG = 1;
  localparam int BIT_CFG_SW_START = 2;
  localparam int POS_CFG_THRESH = 3;
  localparam int W_THRESH = 4;
  // general status fields
  localparam int BIT_GS_TOUCH_RAW = 8;
  localparam int BIT_GS_SUPPLY_RAW = 9;
  localparam int BIT_GS_BUSY = 10;
  // bias bit that connects the touch detector
  localparam int BIT_BIAS_DETECT = 12;
  localparam int W_BIAS = 16;
  // conversion timing
  localparam int GET_DATA_CYCLES = 1;
  localparam int MEASURE_CYCLES = 16;
  localparam int CONV_CYCLES = GET_DATA_CYCLES + MEASURE_CYCLES;
  localparam int SUPPLY_HOLDOFF_CYCLES = 1;
  localparam logic [31:0] RST_GEN_CONFIG = 32'h0000_0000;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;
  localparam logic [31:0] RST_SEQ_CONFIG = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_END = 4'b1000
  } combined_touch_irq_state_t;
endpackage

// >>> design/combined_touch_irq_top.sv
// touch converter sequencer, result fifo, interrupts and register slave
module combined_touch_irq_top
  import combined_touch_irq_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int W_DATA = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_low_pin,
  input wire logic touch_detect_line,
  input wire logic [W_DATA-1:0] conv_result,
  output logic [W_BIAS-1:0] bias_ctrl,
  output logic conv_sample,
  output logic supply_drop_irq,
  output logic touch_detect_irq,
  output logic combined_touch_irq
);
  localparam int W_CNT = $clog2(FIFO_DEPTH + 1);
  localparam int W_PTR = $clog2(FIFO_DEPTH);

  function automatic logic [W_PTR-1:0] ptr_inc(input logic [W_PTR-1:0] p);
    ptr_inc = (p == W_PTR'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // pin synchronisers
  logic supply_s1_r, supply_s2_r, touch_s1_r, touch_s2_r, touch_prev_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_s1_r <= 1'b0;
      supply_s2_r <= 1'b0;
      touch_s1_r <= 1'b0;
      touch_s2_r <= 1'b0;
      touch_prev_r <= 1'b0;
    end else begin
      supply_s1_r <= supply_low_pin;
      supply_s2_r <= supply_s1_r;
      touch_s1_r <= touch_detect_line;
      touch_s2_r <= touch_s1_r;
      touch_prev_r <= touch_s2_r;
    end
  end

  // registers
  logic [31:0] gen_config_r, seq_config_r;
  logic [4:0] irq_mask_r;
  logic [W_BIAS-1:0] bias_r;
  logic [2:0] clr_pulse_r;
  logic seq_done_r, touch_r, supply_r, overrun_r;
  logic [SUPPLY_HOLDOFF_CYCLES-1:0] supply_hold_r;

  // axi write path: address and data taken in either order
  logic aw_held_r, w_held_r, bvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  wire aw_take = s_axi_awvalid && !aw_held_r && !bvalid_r;
  wire w_take = s_axi_wvalid && !w_held_r && !bvalid_r;
  wire wr_go = aw_held_r && w_held_r;
  wire wr_hit_cfg = wr_go && awaddr_r == OFS_GEN_CONFIG;
  wire wr_hit_mask = wr_go && awaddr_r == OFS_IRQ_MASK;
  wire wr_hit_clr = wr_go && awaddr_r == OFS_IRQ_CLEAR;
  wire wr_hit_seq = wr_go && awaddr_r == OFS_SEQ_CONFIG;
  wire wr_hit_bias = wr_go && awaddr_r == OFS_BIAS_CTRL;
  wire wr_known = wr_hit_cfg || wr_hit_mask || wr_hit_clr || wr_hit_seq || wr_hit_bias;
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr[7:0];
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software registers; the clear register holds nothing, it only pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_config_r <= RST_GEN_CONFIG;
      seq_config_r <= RST_SEQ_CONFIG;
      irq_mask_r <= RST_IRQ_MASK;
      bias_r <= '0;
      clr_pulse_r <= 3'b000;
    end else begin
      if (wr_hit_cfg && wstrb_r[0]) gen_config_r[7:0] <= wdata_r[7:0];
      if (wr_hit_seq && wstrb_r[0]) seq_config_r[7:0] <= wdata_r[7:0];
      if (wr_hit_seq && wstrb_r[1]) seq_config_r[15:8] <= wdata_r[15:8];
      if (wr_hit_mask && wstrb_r[0]) irq_mask_r <= wdata_r[4:0];
      if (wr_hit_bias && wstrb_r[0]) bias_r[7:0] <= wdata_r[7:0];
      if (wr_hit_bias && wstrb_r[1]) bias_r[15:8] <= wdata_r[15:8];
      clr_pulse_r <= (wr_hit_clr && wstrb_r[0]) ? wdata_r[2:0] : 3'b000;
    end
  end
  assign bias_ctrl = bias_r;

  // sequencer: measurement count in seq config [3:0], settle cycles in [15:8]
  combined_touch_irq_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [4:0] meas_r, meas_nxt;
  logic in_convert;
  logic [4:0] meas_total;
  logic [7:0] settle_cycles;
  assign meas_total = (seq_config_r[3:0] == 4'h0) ? 5'd16 : {1'b0, seq_config_r[3:0]};
  assign settle_cycles = seq_config_r[15:8];
  assign in_convert = state_r == ST_CONVERT;

  // touch detect only counts while the detector is connected; edge caught
  wire touch_edge = touch_s2_r && !touch_prev_r && bias_r[BIT_BIAS_DETECT];
  wire start_req = gen_config_r[BIT_CFG_SW_START] || gen_config_r[BIT_CFG_CONTINUOUS]
                   || (gen_config_r[BIT_CFG_TOUCH_TRIG] && touch_edge);
  wire conv_done = in_convert && cnt_r == 8'(CONV_CYCLES - 1);
  wire last_meas = meas_r == meas_total - 5'd1;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 8'd1;
    meas_nxt = meas_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 8'd0;
        meas_nxt = 5'd0;
        if (start_req) state_nxt = (settle_cycles == 8'd0) ? ST_CONVERT : ST_SETTLE;
      end
      ST_SETTLE: begin
        if (cnt_r == settle_cycles - 8'd1) begin
          state_nxt = ST_CONVERT;
          cnt_nxt = 8'd0;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          cnt_nxt = 8'd0;
          meas_nxt = meas_r + 5'd1;
          if (last_meas) state_nxt = ST_END;
          else state_nxt = (settle_cycles == 8'd0) ? ST_CONVERT : ST_SETTLE;
        end
      end
      ST_END: begin
        cnt_nxt = 8'd0;
        meas_nxt = 5'd0;
        // continuous mode goes straight on, skipping idle
        if (gen_config_r[BIT_CFG_CONTINUOUS])
          state_nxt = (settle_cycles == 8'd0) ? ST_CONVERT : ST_SETTLE;
        else state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 8'd0;
        meas_nxt = 5'd0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'd0;
      meas_r <= 5'd0;
      conv_sample <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      meas_r <= meas_nxt;
      conv_sample <= conv_done;
    end
  end

  // result fifo; a result arriving when full is dropped
  logic [W_DATA-1:0] fifo_mem [FIFO_DEPTH];
  logic [W_PTR-1:0] wr_ptr_r, rd_ptr_r;
  logic [W_CNT-1:0] fifo_cnt_r;
  wire fifo_full = fifo_cnt_r == W_CNT'(FIFO_DEPTH);
  wire fifo_empty = fifo_cnt_r == '0;
  wire rd_fifo;
  wire push = conv_done && !fifo_full;
  wire pop = rd_fifo && !fifo_empty;
  always_ff @(posedge aclk) begin
    if (push) fifo_mem[wr_ptr_r] <= conv_result;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fifo_cnt_r <= '0;
    end else begin
      if (push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      if (push && !pop) fifo_cnt_r <= fifo_cnt_r + 1'b1;
      else if (pop && !push) fifo_cnt_r <= fifo_cnt_r - 1'b1;
    end
  end

  // interrupt latches: a new event wins over a clear in the same cycle
  wire seq_done_evt = state_r == ST_END;
  wire overrun_evt = conv_done && fifo_full;
  wire supply_ok_to_set = supply_hold_r == '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_done_r <= 1'b0;
      touch_r <= 1'b0;
      supply_r <= 1'b0;
      overrun_r <= 1'b0;
      supply_hold_r <= '0;
    end else begin
      seq_done_r <= seq_done_evt || (seq_done_r && !clr_pulse_r[BIT_CLR_SEQ_DONE]);
      touch_r <= touch_edge || (touch_r && !clr_pulse_r[BIT_CLR_TOUCH]);
      supply_r <= (supply_s2_r && supply_ok_to_set)
                  || (supply_r && !clr_pulse_r[BIT_CLR_SUPPLY]);
      // shift register of clears; the cast keeps the newest holdoff cycles only
      supply_hold_r <= SUPPLY_HOLDOFF_CYCLES'({supply_hold_r, clr_pulse_r[BIT_CLR_SUPPLY]});
      overrun_r <= overrun_evt || (overrun_r && !pop);
    end
  end

  wire watermark = fifo_cnt_r >= W_CNT'(gen_config_r[POS_CFG_THRESH +: W_THRESH]);
  wire [4:0] irq_status = {supply_r, touch_r, seq_done_r, watermark, overrun_r};
  wire [4:0] irq_masked = irq_status & irq_mask_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_drop_irq <= 1'b0;
      touch_detect_irq <= 1'b0;
      combined_touch_irq <= 1'b0;
    end else begin
      supply_drop_irq <= irq_masked[BIT_SUPPLY];
      touch_detect_irq <= irq_masked[BIT_TOUCH];
      combined_touch_irq <= |irq_masked;
    end
  end

  // axi read path
  logic rvalid_r;
  wire [7:0] ar_ofs = s_axi_araddr[7:0];
  wire ar_take = s_axi_arvalid && !rvalid_r;
  assign rd_fifo = ar_take && ar_ofs == OFS_FIFO_DATA;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  logic [31:0] gen_status;
  assign gen_status = {21'h0, state_r != ST_IDLE, supply_s2_r, touch_s2_r,
                       3'h0, fifo_cnt_r};
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ar_ofs)
      OFS_GEN_CONFIG: rd_word = {25'h0, gen_config_r[6:0]};
      OFS_GEN_STATUS: rd_word = gen_status;
      OFS_IRQ_STATUS: rd_word = {27'h0, irq_status};
      OFS_IRQ_MASK: rd_word = {27'h0, irq_mask_r};
      OFS_IRQ_CLEAR: rd_word = 32'h0000_0000;
      OFS_MASKED_STATUS: rd_word = {27'h0, irq_masked};
      OFS_SEQ_CONFIG: rd_word = {16'h0, seq_config_r[15:0]};
      OFS_FIFO_DATA: rd_word = fifo_empty ? 32'h0000_0000
                                          : 32'(fifo_mem[rd_ptr_r]);
      OFS_BIAS_CTRL: rd_word = 32'(bias_r);
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // checks
  property p_seq_done_set;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_END |=> seq_done_r;
  endproperty
  a_seq_done_set: assert property (p_seq_done_set) else $error("seq done not latched");

  property p_seq_done_clear;
    @(posedge aclk) disable iff (!aresetn)
      clr_pulse_r[0] && state_r != ST_END |=> !seq_done_r;
  endproperty
  a_seq_done_clear: assert property (p_seq_done_clear) else $error("seq clear failed");

  property p_conv_len;
    @(posedge aclk) disable iff (!aresetn)
      $rose(in_convert) |-> in_convert [*8] ##1 in_convert [*8] ##1 conv_done;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion not 17 cycles");

  property p_cont_skip_idle;
    @(posedge aclk) disable iff (!aresetn)
      state_r == ST_END && gen_config_r[0] |=> state_r != ST_IDLE;
  endproperty
  a_cont_skip_idle: assert property (p_cont_skip_idle) else $error("idle not skipped");

  property p_combined;
    @(posedge aclk) disable iff (!aresetn)
      |(irq_status & irq_mask_r) |=> combined_touch_irq;
  endproperty
  a_combined: assert property (p_combined) else $error("combined irq missing");

  property p_mask_keeps_status;
    @(posedge aclk) disable iff (!aresetn)
      supply_r && clr_pulse_r[2] == 1'b0 |=> supply_r;
  endproperty
  a_mask_keeps_status: assert property (p_mask_keeps_status) else $error("status lost");

  // a raw drop in the clear cycle wins, so only a quiet pin must see the holdoff
  property p_supply_holdoff;
    @(posedge aclk) disable iff (!aresetn)
      clr_pulse_r[BIT_CLR_SUPPLY] && !supply_s2_r |=> !supply_r ##1 !supply_r;
  endproperty
  a_supply_holdoff: assert property (p_supply_holdoff) else $error("supply reset early");

  property p_overrun_drop;
    @(posedge aclk) disable iff (!aresetn)
      conv_done && fifo_full && !pop |=> overrun_r && fifo_full && $stable(wr_ptr_r);
  endproperty
  a_overrun_drop: assert property (p_overrun_drop) else $error("overrun mishandled");

  property p_clear_pulse;
    @(posedge aclk) disable iff (!aresetn)
      clr_pulse_r != 3'b000 && !wr_hit_clr |=> clr_pulse_r == 3'b000;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear not one cycle");
endmodule

// >>> sim/combined_touch_irq_panel.sv
// panel, bias network and converter model on the far side of the touch block
module combined_touch_irq_panel
  import combined_touch_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic [W_BIAS-1:0] bias_ctrl,
  input wire logic conv_sample,
  input wire logic pen_down,
  input wire logic supply_low,
  output logic touch_detect_line,
  output logic supply_low_pin,
  output logic [9:0] conv_result
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] cnt_r = 10'h100;
  // the detector sees the pen only once the connect bit is set by software
  assign touch_detect_line = pen_down & bias_ctrl[BIT_BIAS_DETECT];
  assign supply_low_pin = supply_low;
  // counting results make a lost or reordered fifo entry visible
  assign conv_result = cnt_r;
  always @(posedge aclk) begin
    if (conv_sample) cnt_r <= cnt_r + 10'h001;
  end
endmodule

// >>> sim/tb.sv
// self-checking bench for the touch interrupt and sequence block
module tb
  import combined_touch_irq_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pen = 1'b0, sup = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tdl, slp, cs, sdi, tdi, cti;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [9:0] cres;
  logic [15:0] bias;
  int n_fail = 0, n_checks = 0, cyc = 0, n_samp = 0;

  combined_touch_irq_top DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_low_pin(slp), .touch_detect_line(tdl), .conv_result(cres),
    .bias_ctrl(bias), .conv_sample(cs), .supply_drop_irq(sdi),
    .touch_detect_irq(tdi), .combined_touch_irq(cti)
  );
  combined_touch_irq_panel PM (
    .aclk(aclk), .bias_ctrl(bias), .conv_sample(cs), .pen_down(pen),
    .supply_low(sup), .touch_detect_line(tdl), .supply_low_pin(slp), .conv_result(cres)
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // the ceiling sits far above the roughly one thousand cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cs) n_samp <= n_samp + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address and data are offered together and each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    rdr(a);
    chk(nm, e, rd & m);
  endtask

  task automatic t_reset;
    // threshold resets to zero, so the level interrupt is active at once
    rchk("irq status", OFS_IRQ_STATUS, 32'h1f, 32'h1 << BIT_WATERMARK);
    rchk("mask", OFS_IRQ_MASK, 32'h1f, {27'h0, RST_IRQ_MASK});
    rchk("seq config", OFS_SEQ_CONFIG, 32'hffff, RST_SEQ_CONFIG);
    chk("combined idle", 32'h0, {31'h0, cti});
    rdr(8'h40);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("unmapped rdata", 32'h0, rd);
    wr(8'h40, 32'h1);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    $display("test reset done");
  endtask

  // fill past 16 entries, then drain while watching overrun and watermark
  task automatic t_fifo;
    int s0;
    logic [9:0] e;
    wr(OFS_SEQ_CONFIG, 32'h1);
    chk("mapped bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    wr(OFS_IRQ_MASK, 32'h1f);
    s0 = n_samp;
    wr(OFS_GEN_CONFIG, 32'h24);
    while (n_samp < s0 + 17) @(posedge aclk);
    wr(OFS_GEN_CONFIG, 32'h20);
    repeat (40) @(posedge aclk);
    rchk("fifo count", OFS_GEN_STATUS, 32'h1f, 32'h10);
    rchk("overrun and level", OFS_IRQ_STATUS, 32'h3, 32'h3);
    chk("combined", 32'h1, {31'h0, cti});
    for (int i = 0; i < 16; i++) begin
      rdr(OFS_FIFO_DATA);
      e = 10'h100 + 10'(s0 + i);
      chk("fifo data", {22'h0, e}, rd & 32'h3ff);
      rchk("overrun", OFS_IRQ_STATUS, 32'h1, 32'h0);
      rchk("watermark", OFS_IRQ_STATUS, 32'h2, {30'h0, (15 - i >= 4), 1'b0});
    end
    $display("test fifo done");
  endtask

  // two gaps between results span exactly one sequence period
  task automatic span(input logic [31:0] cfg, input int per);
    int t[3];
    int k;
    int g;
    wr(OFS_GEN_CONFIG, cfg);
    for (int i = 0; i < 3; i++) begin
      k = n_samp;
      while (n_samp == k) @(posedge aclk);
      t[i] = cyc;
    end
    wr(OFS_GEN_CONFIG, 32'h0);
    g = (t[1] - t[0] < t[2] - t[1]) ? t[1] - t[0] : t[2] - t[1];
    chk("conversion gap", 32'(CONV_CYCLES + 3), 32'(g));
    chk("sequence period", 32'(per), 32'(t[2] - t[0]));
    repeat (60) @(posedge aclk);
  endtask

  task automatic t_timing;
    wr(OFS_SEQ_CONFIG, 32'h0302);
    span(32'h04, 2 + 2 * (CONV_CYCLES + 3));
    span(32'h05, 1 + 2 * (CONV_CYCLES + 3));
    rchk("seq done", OFS_IRQ_STATUS, 32'h4, 32'h4);
    wr(OFS_IRQ_CLEAR, 32'h1);
    repeat (4) @(posedge aclk);
    rchk("seq done clear", OFS_IRQ_STATUS, 32'h4, 32'h0);
    $display("test timing done");
  endtask

  task automatic t_supply;
    @(posedge aclk);
    sup <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk("raw supply", OFS_GEN_STATUS, 32'h200, 32'h200);
    rchk("supply latch", OFS_IRQ_STATUS, 32'h10, 32'h10);
    chk("supply out", 32'h1, {31'h0, sdi});
    chk("combined", 32'h1, {31'h0, cti});
    @(posedge aclk);
    sup <= 1'b0;
    repeat (8) @(posedge aclk);
    rchk("raw supply off", OFS_GEN_STATUS, 32'h200, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h0);
    repeat (4) @(posedge aclk);
    rchk("supply held", OFS_IRQ_STATUS, 32'h10, 32'h10);
    wr(OFS_IRQ_MASK, 32'h0);
    rchk("masked keeps", OFS_IRQ_STATUS, 32'h10, 32'h10);
    rchk("masked view", OFS_MASKED_STATUS, 32'h1f, 32'h0);
    chk("combined masked", 32'h0, {31'h0, cti});
    chk("supply out masked", 32'h0, {31'h0, sdi});
    wr(OFS_IRQ_CLEAR, 32'h4);
    repeat (4) @(posedge aclk);
    rchk("supply clear", OFS_IRQ_STATUS, 32'h10, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1f);
    $display("test supply done");
  endtask

  task automatic t_touch;
    int k;
    wr(OFS_GEN_CONFIG, 32'h02);
    wr(OFS_BIAS_CTRL, 32'h4);
    wr(OFS_BIAS_CTRL, 32'h104);
    wr(OFS_BIAS_CTRL, 32'h1104);
    chk("bias out", 32'h1104, {16'h0, bias});
    k = n_samp;
    @(posedge aclk);
    pen <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk("touch latch", OFS_IRQ_STATUS, 32'h8, 32'h8);
    rchk("raw touch", OFS_GEN_STATUS, 32'h100, 32'h100);
    chk("touch out", 32'h1, {31'h0, tdi});
    repeat (100) @(posedge aclk);
    chk("touch start", 32'h1, {31'h0, n_samp > k});
    wr(OFS_IRQ_CLEAR, 32'h2);
    repeat (30) @(posedge aclk);
    rchk("touch held pen", OFS_IRQ_STATUS, 32'h8, 32'h0);
    chk("touch out cleared", 32'h0, {31'h0, tdi});
    pen <= 1'b0;
    wr(OFS_BIAS_CTRL, 32'h104);
    pen <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk("touch detector off", OFS_IRQ_STATUS, 32'h8, 32'h0);
    pen <= 1'b0;
    wr(OFS_GEN_CONFIG, 32'h0);
    $display("test touch done");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_fifo;
    t_timing;
    t_supply;
    t_touch;
    give_verdict;
  end
endmodule
